// ==== rtl/scs_fifo2.v ====
`timescale 1ns/1ps
module scs_fifo2 #(
  parameter W = 8
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:1];
  reg [1:0] cnt_q;
  reg wr_q;
  reg rd_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge ref_clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= 2'h0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      if (push)
        wr_q <= ~wr_q;
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule // scs_fifo2

// ==== rtl/scs_regs.vh ====
`ifndef SCS_REGS_VH
`define SCS_REGS_VH

// Register addresses
`define SCS_ADDR_CFG 8'hA1
`define SCS_ADDR_CKR 8'hA2
`define SCS_ADDR_DAT 8'hA3
`define SCS_ADDR_CTRL 8'hF8

// Configuration and status register fields
`define SCS_CFG_BUSY 7
`define SCS_CFG_ROLE 6
`define SCS_CFG_PHA 5
`define SCS_CFG_POL 4
`define SCS_CFG_SEL 3
`define SCS_CFG_RAW 2
`define SCS_CFG_SHIFTER_EMPTY_FLAG 1
`define SCS_CFG_RXE 0

// Control register fields
`define SCS_CTRL_DONE 7
`define SCS_CTRL_WCOL 6
`define SCS_CTRL_MODF 5
`define SCS_CTRL_OVR 4
`define SCS_CTRL_MD_HI 3
`define SCS_CTRL_MD_LO 2
`define SCS_CTRL_TXE 1
`define SCS_CTRL_EN 0

// Select mode encodings
`define SCS_MD_3WIRE 2'h0
`define SCS_MD_4WIRE_IN 2'h1

// Reset values
`define SCS_RST_MD 2'h1
`define SCS_RST_CKR 8'h00

// Timing
`define SCS_SEL_FILT 2
`define SCS_BITS 4'h8
`define SCS_HALVES 5'h10

`endif

// ==== rtl/scs_sync.v ====
`timescale 1ns/1ps
module scs_sync #(
  parameter W = 4,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // scs_sync

// ==== rtl/scs_top.v ====
// Overview of operation
// - Status bit 7 reads one while a byte transfer runs, in either role.
// - Bit 6 clear makes the port a target, set makes it the clock master.
// - Phase bit 5 puts data centre on the first clock edge at zero, else second.
// - Polarity bit 4 sets the serial clock idle level, low at zero.
// - Bit 3 reads one while a de-glitched copy of select is low.
// - Bit 2 returns the select pin level with no de-glitching.
// - As target, bit 1 sets when a byte is done, nothing waits to load or store.
// - Bit 1 clears when the shifter is loaded or a serial clock edge shifts.
// - As controller, bit 1 always reads one.
// - As target, bit 0 is one when no unread received byte is held, else zero.
// - As controller, bit 0 always reads one.
// - As target, incoming data is sampled at the centre of each bit.
// - As controller, incoming data is sampled one clock before the bit ends.
// - Select mode 00 ignores select, 01 takes it as input, 1x drives it out.
// - Select low while controller in mode 01 clears role and enable.
// - A 4-wire target acts only while select is low, seen two clocks late through the synchroniser.
`timescale 1ns/1ps
`include "scs_regs.vh"
module scs_top #(
  parameter SEL_FILT = `SCS_SEL_FILT
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Special function register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  // Serial clock pin
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe,
  // Controller-out pin
  input wire mosi_in,
  output reg mosi_out,
  output reg mosi_oe,
  // Target-out pin
  input wire miso_in,
  output reg miso_out,
  output reg miso_oe,
  // Select line pin
  input wire select_line_in,
  output reg select_line_out,
  output reg select_line_oe
);
  // Pin synchronisers
  wire [3:0] pin_s;
  wire sck_s;
  wire mosi_s;
  wire miso_s;
  wire sel_s;

  scs_sync #(.W(4), .INIT(4'h8)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d({select_line_in, miso_in, mosi_in, sck_in}),
    .q(pin_s)
  );
  assign sck_s = pin_s[0];
  assign mosi_s = pin_s[1];
  assign miso_s = pin_s[2];
  assign sel_s = pin_s[3];

  // Software state
  reg controller_role_select_q;
  reg clock_phase_select_q;
  reg clock_idle_level_q;
  reg port_enable_q;
  reg [1:0] select_mode_field_q;
  reg [7:0] ckr_q;
  reg [7:0] tx_hold_q;
  reg tx_full_q;
  reg done_flag_q;
  reg wcol_flag_q;
  reg modf_flag_q;
  reg ovr_flag_q;
  // Engine state
  reg sck_prev_q;
  reg sel_filt_q;
  reg [1:0] filt_cnt_q;
  reg shifter_empty_q;
  reg [7:0] tx_sh_q;
  reg [7:0] rx_sh_q;
  reg out_bit_q;
  reg [3:0] bit_cnt_q;
  reg ctl_act_q;
  reg [4:0] half_q;
  reg [7:0] div_q;
  reg sck_q;
  reg push_q;
  reg [7:0] push_data_q;

  wire rx_in_ready;
  wire rx_valid;
  wire [7:0] rx_data;
  wire rx_pop;
  wire wr_cfg;
  wire wr_ctrl;
  wire wr_dat;
  wire tgt_sel;
  wire tgt_on;
  wire sck_edge;
  wire lead;
  wire trail;
  wire tgt_sample;
  wire tgt_shift;
  wire tgt_done;
  wire tgt_load;
  wire ctl_start;
  wire half_end;
  wire [4:0] half_nx;
  wire mode_fault;
  wire busy;
  wire [7:0] tgt_byte;

  assign wr_cfg = sfr_wr && (sfr_addr == `SCS_ADDR_CFG);
  assign wr_ctrl = sfr_wr && (sfr_addr == `SCS_ADDR_CTRL);
  assign wr_dat = sfr_wr && (sfr_addr == `SCS_ADDR_DAT);
  assign rx_pop = sfr_rd && (sfr_addr == `SCS_ADDR_DAT);

  // Target gating by the select line
  assign tgt_sel = (select_mode_field_q == `SCS_MD_3WIRE) ||
    (!select_mode_field_q[1] && !sel_s);
  assign tgt_on = port_enable_q && !controller_role_select_q &&
    tgt_sel;

  // Serial clock edges seen as target
  assign sck_edge = tgt_on && (sck_s != sck_prev_q);
  assign lead = sck_edge && (sck_s != clock_idle_level_q);
  assign trail = sck_edge && (sck_s == clock_idle_level_q);
  assign tgt_sample = clock_phase_select_q ? trail : lead;
  assign tgt_shift = clock_phase_select_q ? lead : trail;
  assign tgt_done = trail && (clock_phase_select_q ?
    (bit_cnt_q == `SCS_BITS - 4'h1) : (bit_cnt_q == `SCS_BITS));
  assign tgt_load = tgt_on && shifter_empty_q && tx_full_q && !sck_edge;
  assign tgt_byte = clock_phase_select_q ? {rx_sh_q[6:0], mosi_s} : rx_sh_q;

  // Controller bit timing; one half period is ckr_q + 1 clocks
  assign ctl_start = port_enable_q && controller_role_select_q &&
    !ctl_act_q && tx_full_q && rx_in_ready && !push_q;
  assign half_end = ctl_act_q && (div_q == ckr_q);
  assign half_nx = half_q + 5'h1;

  assign mode_fault = port_enable_q && controller_role_select_q &&
    (select_mode_field_q == `SCS_MD_4WIRE_IN) && !sel_filt_q;
  assign busy = ctl_act_q ||
    (tgt_on && (bit_cnt_q != 4'h0));

  scs_fifo2 #(.W(8)) u_rxbuf (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(push_q),
    .in_ready(rx_in_ready),
    .in_data(push_data_q),
    .out_valid(rx_valid),
    .out_ready(rx_pop),
    .out_data(rx_data)
  );

  // Select de-glitch filter
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_filt_q <= 1'b1;
      filt_cnt_q <= 2'h0;
    end
    else if (sel_s == sel_filt_q)
      filt_cnt_q <= 2'h0;
    else if (filt_cnt_q == SEL_FILT[1:0] - 2'h1)
    begin
      sel_filt_q <= sel_s;
      filt_cnt_q <= 2'h0;
    end
    else
      filt_cnt_q <= filt_cnt_q + 2'h1;
  end

  // Software registers and flags; hardware set wins over clear
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      controller_role_select_q <= 1'b0;
      clock_phase_select_q <= 1'b0;
      clock_idle_level_q <= 1'b0;
      port_enable_q <= 1'b0;
      select_mode_field_q <= `SCS_RST_MD;
      ckr_q <= `SCS_RST_CKR;
      tx_hold_q <= 8'h00;
      tx_full_q <= 1'b0;
      done_flag_q <= 1'b0;
      wcol_flag_q <= 1'b0;
      modf_flag_q <= 1'b0;
      ovr_flag_q <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
      begin
        controller_role_select_q <= sfr_wdata[`SCS_CFG_ROLE];
        clock_phase_select_q <= sfr_wdata[`SCS_CFG_PHA];
        clock_idle_level_q <= sfr_wdata[`SCS_CFG_POL];
      end
      if (wr_ctrl)
      begin
        select_mode_field_q <=
          sfr_wdata[`SCS_CTRL_MD_HI:`SCS_CTRL_MD_LO];
        port_enable_q <= sfr_wdata[`SCS_CTRL_EN];
        done_flag_q <= sfr_wdata[`SCS_CTRL_DONE];
        wcol_flag_q <= sfr_wdata[`SCS_CTRL_WCOL];
        modf_flag_q <= sfr_wdata[`SCS_CTRL_MODF];
        ovr_flag_q <= sfr_wdata[`SCS_CTRL_OVR];
      end
      if (sfr_wr && (sfr_addr == `SCS_ADDR_CKR))
        ckr_q <= sfr_wdata;
      if (ctl_start || tgt_load || (tgt_done && tx_full_q))
        tx_full_q <= 1'b0;
      if (wr_dat)
      begin
        if (tx_full_q)
          wcol_flag_q <= 1'b1;
        else
        begin
          tx_hold_q <= sfr_wdata;
          tx_full_q <= 1'b1;
        end
      end
      if (mode_fault)
      begin
        modf_flag_q <= 1'b1;
        controller_role_select_q <= 1'b0;
        port_enable_q <= 1'b0;
      end
      if (push_q)
      begin
        done_flag_q <= 1'b1;
        if (!rx_in_ready)
          ovr_flag_q <= 1'b1;
      end
    end
  end

  // Shift engine for both roles
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sck_prev_q <= 1'b0;
      shifter_empty_q <= 1'b1;
      tx_sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      out_bit_q <= 1'b0;
      bit_cnt_q <= 4'h0;
      ctl_act_q <= 1'b0;
      half_q <= 5'h00;
      div_q <= 8'h00;
      sck_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= 8'h00;
    end
    else
    begin
      sck_prev_q <= sck_s;
      push_q <= 1'b0;
      if (!ctl_act_q)
        sck_q <= clock_idle_level_q;
      if (ctl_start)
      begin
        ctl_act_q <= 1'b1;
        half_q <= 5'h00;
        div_q <= 8'h00;
        out_bit_q <= tx_hold_q[7];
        tx_sh_q <= {tx_hold_q[6:0], 1'b0};
        if (clock_phase_select_q)
          sck_q <= ~clock_idle_level_q;
      end
      else if (ctl_act_q)
      begin
        if (!port_enable_q || !controller_role_select_q)
          ctl_act_q <= 1'b0;
        else if (half_end)
        begin
          div_q <= 8'h00;
          half_q <= half_nx;
          if (half_q[0])
            rx_sh_q <= {rx_sh_q[6:0], miso_s};
          if (half_nx == `SCS_HALVES)
          begin
            ctl_act_q <= 1'b0;
            sck_q <= clock_idle_level_q;
            push_q <= 1'b1;
            push_data_q <= {rx_sh_q[6:0], miso_s};
          end
          else
          begin
            sck_q <= ~sck_q;
            if (!half_nx[0])
            begin
              out_bit_q <= tx_sh_q[7];
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            end
          end
        end
        else
          div_q <= div_q + 8'h01;
      end
      else if (!tgt_on)
        bit_cnt_q <= 4'h0;
      else
      begin
        if (sck_edge)
          shifter_empty_q <= 1'b0;
        if (tgt_load)
        begin
          shifter_empty_q <= 1'b0;
          tx_sh_q <= tx_hold_q;
          if (!clock_phase_select_q)
            out_bit_q <= tx_hold_q[7];
        end
        if (tgt_sample)
        begin
          rx_sh_q <= {rx_sh_q[6:0], mosi_s};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        if (tgt_shift && !tgt_done)
        begin
          out_bit_q <= clock_phase_select_q ? tx_sh_q[7] : tx_sh_q[6];
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
        if (tgt_done)
        begin
          bit_cnt_q <= 4'h0;
          push_q <= 1'b1;
          push_data_q <= tgt_byte;
          if (tx_full_q)
          begin
            tx_sh_q <= tx_hold_q;
            if (!clock_phase_select_q)
              out_bit_q <= tx_hold_q[7];
          end
          else
            shifter_empty_q <= rx_in_ready;
        end
      end
    end
  end

  // Pin drivers and read data
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      select_line_out <= 1'b1;
      select_line_oe <= 1'b0;
      sfr_rdata <= 8'h00;
    end
    else
    begin
      sck_out <= sck_q;
      sck_oe <= port_enable_q && controller_role_select_q;
      mosi_out <= out_bit_q;
      mosi_oe <= port_enable_q && controller_role_select_q;
      miso_out <= out_bit_q;
      miso_oe <= tgt_on;
      select_line_out <= select_mode_field_q[0];
      select_line_oe <= port_enable_q &&
        select_mode_field_q[1];
      if (sfr_rd)
      begin
        case (sfr_addr)
          `SCS_ADDR_CFG:
            sfr_rdata <= {busy, controller_role_select_q,
              clock_phase_select_q, clock_idle_level_q,
              !sel_filt_q,
              sel_s,
              controller_role_select_q | shifter_empty_q,
              controller_role_select_q | !rx_valid};
          `SCS_ADDR_CTRL:
            sfr_rdata <= {done_flag_q, wcol_flag_q, modf_flag_q,
              ovr_flag_q, select_mode_field_q, !tx_full_q,
              port_enable_q};
          `SCS_ADDR_CKR:
            sfr_rdata <= ckr_q;
          `SCS_ADDR_DAT:
            sfr_rdata <= rx_data;
          default:
            sfr_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // scs_top

// ==== sim/scs_peer.sv ====
`timescale 1ns/1ps
module scs_peer (
  // Lines from the device
  input logic tgt_en,
  input logic dsck,
  input logic dmosi,
  input logic dmiso,
  // Lines driven here
  output logic sck = 1'b0,
  output logic mosi = 1'b0,
  output logic sel_b = 1'b1,
  output logic miso = 1'b0
);
  logic pol = 1'b0;
  logic pha = 1'b0;
  logic [7:0] rx_q = 8'h00;
  logic [7:0] tx_q = 8'h00;
  // Controller role: one byte, 160 ns clock period
  task automatic xfer(input logic [7:0] v);
    int i;
    sck = pol;
    #100 sel_b = 1'b0;
    #200;
    for (i = 7; i >= 0; i--)
    begin
      if (!pha)
        mosi = v[i];
      #80 sck = ~pol;
      if (pha)
        mosi = v[i];
      else
        rx_q = {rx_q[6:0], dmiso};
      #80 sck = pol;
      if (pha)
        rx_q = {rx_q[6:0], dmiso};
    end
    #200 sel_b = 1'b1;
    mosi = ~mosi;
  endtask
  // Target role, phase 0: sample leading, shift trailing
  always @(posedge tgt_en)
    miso = tx_q[7];
  always @(dsck)
  begin
    if (tgt_en && dsck != pol)
      rx_q = {rx_q[6:0], dmosi};
    else if (tgt_en)
    begin
      tx_q = tx_q << 1;
      miso = tx_q[7];
    end
  end
endmodule // scs_peer

// ==== sim/scs_top_properties.sv ====
`timescale 1ns/1ps
module scs_top_properties #(
  parameter SEL_FILT = 2
) (
  // Clock and reset
  input logic ref_clk,
  input logic rst_b,
  // Register port
  input logic [7:0] sfr_addr,
  input logic sfr_wr,
  input logic sfr_rd,
  input logic [7:0] sfr_wdata,
  input logic [7:0] sfr_rdata,
  // Serial pins
  input logic sck_in,
  input logic sck_out,
  input logic sck_oe,
  input logic mosi_in,
  input logic mosi_out,
  input logic mosi_oe,
  input logic miso_in,
  input logic miso_out,
  input logic miso_oe,
  input logic select_line_in,
  input logic select_line_out,
  input logic select_line_oe
);
  logic [1:0] mode_q;
  logic [1:0] cfg_q;
  logic [3:0] ss_q;
  logic sel_prev_q;
  logic rd_cfg;
  logic sel_still;
  assign rd_cfg = sfr_rd && sfr_addr == 8'hA1;
  assign sel_still = select_line_in == sel_prev_q;
  // Shadow of written fields and select stability count
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_q <= 2'h1;
      cfg_q <= 2'h0;
      ss_q <= 4'h0;
      sel_prev_q <= 1'b1;
    end
    else
    begin
      if (sfr_wr && sfr_addr == 8'hF8)
        mode_q <= sfr_wdata[3:2];
      if (sfr_wr && sfr_addr == 8'hA1)
        cfg_q <= sfr_wdata[5:4];
      sel_prev_q <= select_line_in;
      if (!sel_still)
        ss_q <= 4'h0;
      else if (ss_q != 4'hF)
        ss_q <= ss_q + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_busy;
    rd_cfg ##1 (sck_oe && sck_out != cfg_q[0]) |-> sfr_rdata[7];
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy low mid transfer");
  property p_wr;
    rd_cfg |=> sfr_rdata[5:4] == $past(cfg_q);
  endproperty
  a_wr: assert property (p_wr)
    else $error("phase or polarity lost");
  property p_flags;
    rd_cfg ##1 sfr_rdata[6] |-> sfr_rdata[1:0] == 2'h3;
  endproperty
  a_flags: assert property (p_flags)
    else $error("controller flags not one");
  property p_idle;
    $rose(sck_oe) |-> sck_out == cfg_q[0];
  endproperty
  a_idle: assert property (p_idle)
    else $error("clock idle level wrong");
  property p_raw;
    rd_cfg && sel_still && ss_q >= 4'h3
      |=> sfr_rdata[2] == $past(select_line_in);
  endproperty
  a_raw: assert property (p_raw)
    else $error("raw select bit wrong");
  property p_sel;
    rd_cfg && sel_still && ss_q > SEL_FILT + 5
      |=> sfr_rdata[3] == !$past(select_line_in);
  endproperty
  a_sel: assert property (p_sel)
    else $error("selected flag wrong");
  property p_fault;
    (sck_oe && mode_q == 2'h1 && !select_line_in) ##1 (!select_line_in)[*8]
      |=> !sck_oe;
  endproperty
  a_fault: assert property (p_fault)
    else $error("mode fault kept clock drive");
  property p_quiet;
    mode_q == 2'h1 && select_line_in && sel_still && ss_q > SEL_FILT + 5
      |-> !miso_oe;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("target drove while unselected");
endmodule // scs_top_properties
bind scs_top scs_top_properties #(.SEL_FILT(SEL_FILT)) u_props (
  .ref_clk(ref_clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .sck_in(sck_in), .sck_out(sck_out),
  .sck_oe(sck_oe), .mosi_in(mosi_in), .mosi_out(mosi_out),
  .mosi_oe(mosi_oe), .miso_in(miso_in), .miso_out(miso_out),
  .miso_oe(miso_oe), .select_line_in(select_line_in),
  .select_line_out(select_line_out), .select_line_oe(select_line_oe)
);

// ==== sim/tb_scs_top.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb_scs_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic sel_out, sel_oe, p_sck, p_mosi, p_sel_b, p_miso;
  logic tgt_en = 1'b0;
  logic [7:0] d;
  int err_count = 0;
  int n_tests = 0;
  int m;
  wire sck_in = sck_oe ? sck_out : p_sck;
  wire mosi_in = mosi_oe ? mosi_out : p_mosi;
  wire miso_in = miso_oe ? miso_out : p_miso;
  wire sel_in = sel_oe ? sel_out : p_sel_b;
  scs_top uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .sck_in(sck_in), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_in(mosi_in), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_in), .miso_out(miso_out),
    .miso_oe(miso_oe), .select_line_in(sel_in),
    .select_line_out(sel_out), .select_line_oe(sel_oe)
  );
  scs_peer peer (
    .tgt_en(tgt_en), .dsck(sck_in), .dmosi(mosi_in), .dmiso(miso_in),
    .sck(p_sck), .mosi(p_mosi), .sel_b(p_sel_b), .miso(p_miso)
  );
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1 v = sfr_rdata;
  endtask
  task automatic t_reset;
    rd(8'hA1, d);
    `CHK(d, 8'h07)
    rd(8'h00, d);
    `CHK(d, 8'h00)
  endtask
  task automatic t_ro;
    wr(8'hA1, 8'hFF);
    rd(8'hA1, d);
    `CHK(d, 8'h77)
    wr(8'hA1, 8'h00);
  endtask
  task automatic t_target;
    for (m = 0; m < 4; m++)
    begin
      peer.pha = m[1];
      peer.pol = m[0];
      wr(8'hF8, 8'h00);
      wr(8'hA1, {2'h0, m[1:0], 4'h0});
      wr(8'hF8, 8'h05);
      wr(8'hA3, 8'hA5 ^ m[7:0]);
      rd(8'hA1, d);
      `CHK(d[1], 1'b1)
      fork
        peer.xfer(8'h3C + m[7:0]);
        begin
          #150;
          rd(8'hA1, d);
          `CHK(d[1], 1'b0)
          #600;
          rd(8'hA1, d);
          `CHK({d[7], d[3]}, 2'h3)
        end
      join
      repeat (8) @(posedge ref_clk);
      rd(8'hA1, d);
      `CHK(d, {2'h0, m[1:0], 4'h6})
      rd(8'hA3, d);
      `CHK(d, 8'h3C + m[7:0])
      `CHK(peer.rx_q, 8'hA5 ^ m[7:0])
      rd(8'hA1, d);
      `CHK(d[0], 1'b1)
    end
  endtask
  task automatic t_ctrl;
    wr(8'hF8, 8'h00);
    wr(8'hA1, 8'h50);
    wr(8'hA2, 8'h07);
    peer.pol = 1'b1;
    peer.pha = 1'b0;
    wr(8'hF8, 8'h01);
    repeat (4) @(posedge ref_clk);
    peer.tx_q = 8'hC3;
    tgt_en = 1'b1;
    wr(8'hA3, 8'h96);
    d = 8'h80;
    for (m = 0; m < 80 && d[7] !== 1'b0; m++)
      rd(8'hA1, d);
    `CHK(d, 8'h57)
    rd(8'hA3, d);
    `CHK(d, 8'hC3)
    `CHK(peer.rx_q, 8'h96)
    tgt_en = 1'b0;
  endtask
  task automatic t_fault;
    wr(8'hF8, 8'h05);
    repeat (4) @(posedge ref_clk);
    peer.sel_b <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rd(8'hF8, d);
    `CHK(d, 8'h26)
    rd(8'hA1, d);
    `CHK(d[7:2], 6'h06)
    peer.sel_b <= 1'b1;
  endtask
  task automatic t_sel_out;
    wr(8'hF8, 8'h09);
    wr(8'hA3, 8'h11);
    wr(8'hA3, 8'h22);
    repeat (4) @(posedge ref_clk);
    rd(8'hA1, d);
    `CHK(d[3:2], 2'h2)
    rd(8'hF8, d);
    `CHK(d, 8'h49)
    wr(8'hF8, 8'h0D);
    repeat (8) @(posedge ref_clk);
    rd(8'hA1, d);
    `CHK(d[3:2], 2'h1)
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_count++;
    finish_test;
  end
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset;
    t_ro;
    t_target;
    t_ctrl;
    t_fault;
    t_sel_out;
    finish_test;
  end
endmodule // tb_scs_top
